// file: src/stg_regs.svh
`ifndef STG_REGS_SVH
`define STG_REGS_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define STG_PWM_W      6

// ----------------------------------------------------------------------
// alarm codes (field of ALARM_CODE)
// ----------------------------------------------------------------------
`define STG_CODE_BOTH  2'h0
`define STG_CODE_A_OFF 2'h1
`define STG_CODE_B_OFF 2'h2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define STG_RST_ON     1'b0
`define STG_RST_PWM    6'h00
`define STG_RST_CODE   2'h0

`endif

// file: src/stg_pkg.sv
`include "stg_regs.svh"

package stg_pkg;

  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  typedef enum logic {ST_RUN, ST_STOP} stg_state_e;
  typedef logic [1:0]            stg_code_t;
  typedef logic [`STG_PWM_W-1:0] stg_pwm_t;

endpackage : stg_pkg

// file: src/stg_path.sv
`timescale 1ns/1ps
`include "stg_regs.svh"

module stg_path (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // safe input pin and gate signals
  input  wire logic              safe_in,
  input  wire stg_pkg::stg_pwm_t pwm_in,
  // synchronised level and gated signals
  output logic                   on_q,
  output stg_pkg::stg_pwm_t      pwm_q
);
  import stg_pkg::*;

  logic     meta_q;
  logic     meta_d;
  logic     on_d;
  stg_pwm_t pwm_d;

  // --------------------------------------------------------------------
  // two-stage synchroniser and independent gate
  // --------------------------------------------------------------------
  always_comb begin
    meta_d = safe_in;
    on_d   = meta_q;
    pwm_d  = on_q ? pwm_in : stg_pwm_t'(`STG_RST_PWM);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= `STG_RST_ON;
      on_q   <= `STG_RST_ON;
      pwm_q  <= `STG_RST_PWM;
    end else begin
      meta_q <= meta_d;
      on_q   <= on_d;
      pwm_q  <= pwm_d;
    end
  end

endmodule : stg_path

// file: src/stg_gate.sv
// Contract
// - two safe channels, each judged separately
// - either channel off enters torque off
// - torque off suppresses every gate signal
// - each channel blocks gates on own path
// - alarm code names which channel was off on entering torque off
// - stop feedback output shows real state
// - torque off active from reset, no setup
`timescale 1ns/1ps
`include "stg_regs.svh"

module stg_gate (
  // clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RST_B,
  // safe input pins
  input  wire logic              SAFE_INPUT_A,
  input  wire logic              SAFE_INPUT_B,
  // gate signals from modulator
  input  wire stg_pkg::stg_pwm_t PWM_IN,
  // alarm clear request
  input  wire logic              ALARM_CLR,
  // gate signals to power stage
  output stg_pkg::stg_pwm_t      PWM_OUT,
  // channel states
  output logic                   CHANNEL_A_STATE,
  output logic                   CHANNEL_B_STATE,
  // stop state and alarm
  output logic                   STOP_STATE_FEEDBACK,
  output logic                   ALARM_VALID,
  output stg_pkg::stg_code_t     ALARM_CODE
);
  import stg_pkg::*;

  // --------------------------------------------------------------------
  // code of a channel combination
  // --------------------------------------------------------------------
  function automatic stg_code_t code_of(input logic a, input logic b);
    stg_code_t c;
    c = stg_code_t'(`STG_CODE_BOTH);
    if (a && !b) begin
      c = stg_code_t'(`STG_CODE_B_OFF);
    end else if (!a && b) begin
      c = stg_code_t'(`STG_CODE_A_OFF);
    end
    return c;
  endfunction : code_of

  // --------------------------------------------------------------------
  // channel paths
  // --------------------------------------------------------------------
  logic     a_on;
  logic     b_on;
  stg_pwm_t a_pwm;
  stg_pwm_t b_pwm;

  stg_path u_path_a (
    .clk     (CORE_CLK),
    .rst_b   (RST_B),
    .safe_in (SAFE_INPUT_A),
    .pwm_in  (PWM_IN),
    .on_q    (a_on),
    .pwm_q   (a_pwm)
  );

  stg_path u_path_b (
    .clk     (CORE_CLK),
    .rst_b   (RST_B),
    .safe_in (SAFE_INPUT_B),
    .pwm_in  (PWM_IN),
    .on_q    (b_on),
    .pwm_q   (b_pwm)
  );

  // --------------------------------------------------------------------
  // stop state machine and alarm
  // --------------------------------------------------------------------
  stg_state_e state_q;
  stg_state_e state_d;
  stg_code_t  code_q;
  stg_code_t  code_d;

  always_comb begin
    state_d = state_q;
    code_d  = code_q;
    case (state_q)
      ST_RUN: begin
        if (!a_on || !b_on) begin
          state_d = ST_STOP;
          code_d  = code_of(a_on, b_on);
        end
      end
      ST_STOP: begin
        // leave only when clean and cleared
        if (ALARM_CLR && a_on && b_on) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_STOP;
        code_d  = stg_code_t'(`STG_CODE_BOTH);
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      state_q <= ST_STOP;
      code_q  <= `STG_RST_CODE;
    end else begin
      state_q <= state_d;
      code_q  <= code_d;
    end
  end

  // --------------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------------
  stg_pwm_t  pwm_d;
  logic      stop_d;
  logic      cha_d;
  logic      chb_d;

  always_comb begin
    stop_d = (state_d == ST_STOP);
    cha_d  = a_on;
    chb_d  = b_on;
    pwm_d  = stop_d ? stg_pwm_t'(`STG_RST_PWM) : (a_pwm & b_pwm);
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      PWM_OUT             <= `STG_RST_PWM;
      CHANNEL_A_STATE     <= `STG_RST_ON;
      CHANNEL_B_STATE     <= `STG_RST_ON;
      STOP_STATE_FEEDBACK <= 1'b1;
      ALARM_VALID         <= 1'b1;
      ALARM_CODE          <= `STG_RST_CODE;
    end else begin
      PWM_OUT             <= pwm_d;
      CHANNEL_A_STATE     <= cha_d;
      CHANNEL_B_STATE     <= chb_d;
      STOP_STATE_FEEDBACK <= stop_d;
      ALARM_VALID         <= stop_d;
      ALARM_CODE          <= code_d;
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);

  property p_chan_state;
    ##1 (CHANNEL_A_STATE == $past(a_on)) && (CHANNEL_B_STATE == $past(b_on));
  endproperty
  a_chan_state: assert property (p_chan_state)
    else $error("channel state does not follow input");

  property p_a_off_stop;
    !a_on |=> STOP_STATE_FEEDBACK && (PWM_OUT == '0);
  endproperty
  a_a_off_stop: assert property (p_a_off_stop)
    else $error("channel A off did not stop");

  property p_b_off_stop;
    !b_on |=> STOP_STATE_FEEDBACK && (PWM_OUT == '0);
  endproperty
  a_b_off_stop: assert property (p_b_off_stop)
    else $error("channel B off did not stop");

  property p_stop_blocks;
    STOP_STATE_FEEDBACK |-> (PWM_OUT == '0);
  endproperty
  a_stop_blocks: assert property (p_stop_blocks)
    else $error("gates active during torque off");

  property p_path_a;
    !a_on |=> (a_pwm == '0) && (PWM_OUT == '0);
  endproperty
  a_path_a: assert property (p_path_a)
    else $error("path A did not block");

  property p_path_b;
    !b_on |=> (b_pwm == '0) && (PWM_OUT == '0);
  endproperty
  a_path_b: assert property (p_path_b)
    else $error("path B did not block");

  property p_pass;
    (state_q == ST_RUN) && a_on && b_on |=> !ALARM_VALID
      && (PWM_OUT == $past(a_pwm & b_pwm));
  endproperty
  a_pass: assert property (p_pass)
    else $error("gates not passed with both channels on");

  property p_code;
    (state_q == ST_RUN) && !(a_on && b_on) |=> ALARM_VALID
      && (ALARM_CODE == ($past(a_on) ? stg_code_t'(`STG_CODE_B_OFF)
        : ($past(b_on) ? stg_code_t'(`STG_CODE_A_OFF)
        : stg_code_t'(`STG_CODE_BOTH))));
  endproperty
  a_code: assert property (p_code)
    else $error("wrong alarm code");

  property p_leave;
    $fell(STOP_STATE_FEEDBACK) |-> $past(ALARM_CLR && a_on && b_on);
  endproperty
  a_leave: assert property (p_leave)
    else $error("feedback left stop without cause");

  property p_reset_stop;
    $rose(RST_B) |-> STOP_STATE_FEEDBACK ##1 STOP_STATE_FEEDBACK;
  endproperty
  a_reset_stop: assert property (p_reset_stop)
    else $error("not in torque off after reset");

  property p_hold;
    STOP_STATE_FEEDBACK && !(ALARM_CLR && a_on && b_on)
      |=> STOP_STATE_FEEDBACK && $stable(ALARM_CODE);
  endproperty
  a_hold: assert property (p_hold)
    else $error("alarm not held");

  property p_cv_a_off;
    (state_q == ST_RUN) ##1 (STOP_STATE_FEEDBACK
      && ALARM_CODE == stg_code_t'(`STG_CODE_A_OFF));
  endproperty
  c_cv_a_off: cover property (p_cv_a_off);

  property p_cv_b_off;
    (state_q == ST_RUN) ##1 (STOP_STATE_FEEDBACK
      && ALARM_CODE == stg_code_t'(`STG_CODE_B_OFF));
  endproperty
  c_cv_b_off: cover property (p_cv_b_off);

  property p_cv_clear;
    STOP_STATE_FEEDBACK ##1 !STOP_STATE_FEEDBACK ##1 (PWM_OUT != '0);
  endproperty
  c_cv_clear: cover property (p_cv_clear);

endmodule : stg_gate

// file: tb/stg_ctl.sv
`timescale 1ns/1ps

module stg_ctl (
  // clock
  input  wire logic clk,
  // wanted contact levels
  input  wire logic want_a,
  input  wire logic want_b,
  // safe input pins
  output logic      safe_a,
  output logic      safe_b
);
  // ----
  // relay contacts
  // ----
  // unpowered reads off, then contacts move off the sampling edge
  initial begin
    safe_a = 1'b0;
    safe_b = 1'b0;
    forever begin
      @(negedge clk);
      safe_a <= want_a;
      safe_b <= want_b;
    end
  end
endmodule : stg_ctl

// file: tb/stg_gate_tb.sv
`timescale 1ns/1ps
`include "stg_regs.svh"

module stg_gate_tb;
  import stg_pkg::*;
  // ----
  // signals
  // ----
  logic      core_clk = 1'b0;
  logic      rst_b    = 1'b0;
  logic      want_a   = 1'b0;
  logic      want_b   = 1'b0;
  logic      alarm_clr = 1'b0;
  logic      sa, sb, cha, chb, stop, valid;
  stg_pwm_t  pwm_in   = 6'h00;
  stg_pwm_t  pwm_out;
  stg_code_t code;
  int        n_fail      = 0;
  int        checks_done = 0;

  always #10 core_clk = ~core_clk;

  stg_ctl ctl (.clk(core_clk), .want_a(want_a), .want_b(want_b),
               .safe_a(sa), .safe_b(sb));

  stg_gate DUT (.CORE_CLK(core_clk), .RST_B(rst_b), .SAFE_INPUT_A(sa),
                .SAFE_INPUT_B(sb), .PWM_IN(pwm_in), .ALARM_CLR(alarm_clr),
                .PWM_OUT(pwm_out), .CHANNEL_A_STATE(cha),
                .CHANNEL_B_STATE(chb), .STOP_STATE_FEEDBACK(stop),
                .ALARM_VALID(valid), .ALARM_CODE(code));

  // ----
  // helpers
  // ----
  task chk_state(input logic [11:0] exp);
    checks_done++;
    if ({pwm_out, cha, chb, stop, valid, code} !== exp) begin
      n_fail++;
      $display("mismatch at %0t: outputs %h exp %h", $time,
               {pwm_out, cha, chb, stop, valid, code}, exp);
    end
  endtask : chk_state

  task set_pins(input logic a, input logic b);
    @(negedge core_clk);
    want_a <= a;
    want_b <= b;
    repeat (5) @(negedge core_clk);
  endtask : set_pins

  task pulse_clr;
    @(negedge core_clk);
    alarm_clr <= 1'b1;
    @(negedge core_clk);
    alarm_clr <= 1'b0;
    repeat (3) @(negedge core_clk);
  endtask : pulse_clr

  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // ----
  // scenarios
  // ----
  task test_reset;
    chk_state({6'h00, 2'b00, 2'b11, `STG_CODE_BOTH});
    pulse_clr;
    chk_state({6'h00, 2'b00, 2'b11, `STG_CODE_BOTH});
    $display("test reset done");
  endtask : test_reset

  task test_run(input stg_pwm_t pw);
    pwm_in <= pw;
    set_pins(1'b1, 1'b1);
    chk_state({6'h00, 2'b11, 2'b11, `STG_CODE_BOTH});
    pulse_clr;
    chk_state({pw, 2'b11, 2'b00, `STG_CODE_BOTH});
    $display("test run done");
  endtask : test_run

  task test_stop(input logic a, input logic b, input stg_code_t c,
                 input stg_pwm_t pw);
    pwm_in <= pw;
    set_pins(a, b);
    chk_state({6'h00, a, b, 2'b11, c});
    set_pins(1'b0, 1'b0);
    chk_state({6'h00, 2'b00, 2'b11, c});
    set_pins(1'b1, 1'b0);
    pulse_clr;
    chk_state({6'h00, 2'b10, 2'b11, c});
    set_pins(1'b1, 1'b1);
    chk_state({6'h00, 2'b11, 2'b11, c});
    pulse_clr;
    chk_state({pw, 2'b11, 2'b00, c});
    $display("test stop %b%b done", a, b);
  endtask : test_stop

  task test_rst_mid;
    @(negedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk_state({6'h00, 2'b00, 2'b11, `STG_CODE_BOTH});
    rst_b <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk_state({6'h00, 2'b00, 2'b11, `STG_CODE_BOTH});
    pulse_clr;
    chk_state({pwm_in, 2'b11, 2'b00, `STG_CODE_BOTH});
    $display("test reset mid done");
  endtask : test_rst_mid

  // ----
  // main sequence
  // ----
  initial begin
    repeat (12) @(negedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(negedge core_clk);
    test_reset;
    test_run(6'h2D);
    test_stop(1'b0, 1'b1, `STG_CODE_A_OFF, 6'h3F);
    test_stop(1'b1, 1'b0, `STG_CODE_B_OFF, 6'h15);
    test_stop(1'b0, 1'b0, `STG_CODE_BOTH, 6'h2A);
    test_rst_mid;
    give_verdict;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict;
  end
endmodule : stg_gate_tb
